//--- hdl/mbs_link_setup.sv
// Modbus RTU slave link setup: switches, settings, addressing, timing
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
module mbs_link_setup #(
  parameter int MS_CYC = mbs_pkg::CLK_HZ / mbs_pkg::MS_PER_S,
  parameter int GAP_SLOW_CYC =
    mbs_pkg::GAP_SLOW_US * (mbs_pkg::CLK_HZ / mbs_pkg::US_PER_S),
  parameter int GAP_MID_CYC =
    mbs_pkg::GAP_MID_US * (mbs_pkg::CLK_HZ / mbs_pkg::US_PER_S),
  parameter int GAP_FAST_CYC =
    mbs_pkg::GAP_FAST_US * (mbs_pkg::CLK_HZ / mbs_pkg::US_PER_S)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Switches
  input wire logic rateSelBit0,
  input wire logic rateSelBit1,
  input wire logic rateSelBit2,
  input wire logic addrExtensionSwitch,
  input wire logic [3:0] addrRotarySelector,
  // Frame processor events
  input wire logic frameRcvd,
  input wire logic [7:0] frameAddr,
  input wire logic commErr,
  input wire logic procDone,
  // Link settings to the character engine
  output logic linkEnable,
  output logic [15:0] bitDiv,
  output logic [1:0] parityMode,
  output logic twoStopBits,
  output logic [4:0] slaveAddr,
  // Request and response control
  output logic execReq,
  output logic execBcast,
  output logic respGo,
  // Alarms and interrupt
  output logic timeoutAlarm,
  output logic errorAlarm,
  output logic irq
);
  import mbs_pkg::*;

  function automatic logic [15:0] calc_bit_div(input logic [2:0] code);
    case (code)
      RATE_9600: calc_bit_div = 16'(CLK_HZ / BAUD_9600);
      RATE_19200: calc_bit_div = 16'(CLK_HZ / BAUD_19200);
      RATE_38400: calc_bit_div = 16'(CLK_HZ / BAUD_38400);
      RATE_57600: calc_bit_div = 16'(CLK_HZ / BAUD_57600);
      RATE_115200: calc_bit_div = 16'(CLK_HZ / BAUD_115200);
      default: calc_bit_div = 16'h0000;
    endcase
  endfunction

  // Modbus fixes the gap at 1.75 ms above 19200 bps
  function automatic logic [19:0] calc_gap(input logic [2:0] code);
    case (code)
      RATE_9600: calc_gap = 20'(GAP_SLOW_CYC);
      RATE_19200: calc_gap = 20'(GAP_MID_CYC);
      default: calc_gap = 20'(GAP_FAST_CYC);
    endcase
  endfunction

  // Captured switches and the gap length derived from them
  logic [2:0] rateCode;
  logic addrExt;
  logic [3:0] addrRot;
  logic [19:0] gapCyc;
  // Settings
  logic [6:0] txWait;
  logic [13:0] timeoutMs;
  logic [3:0] errLimit;
  logic [IRQ_W-1:0] irqStat;
  logic [IRQ_W-1:0] irqMask;
  // Bus pipeline
  logic wrPend;
  logic [7:0] wrAddr;
  logic rdLate;
  logic [7:0] rdAddr;
  // Timing
  logic [15:0] msCnt;
  logic [13:0] toCnt;
  logic toArmed;
  logic [3:0] errCnt;
  mbs_resp_state_t state;
  logic [19:0] seqCnt;
  logic [6:0] waitMs;
  logic procSeen;

  // Bus decode
  wire addrPhase = hsel & htrans[1] & hready;
  wire rdReq = addrPhase & ~hwrite;
  wire rdStall = rdReq & wrPend;
  wire [7:0] muxAddr = rdLate ? rdAddr : haddr[7:0];
  wire wrParity = wrPend & (wrAddr == OFS_PARITY);
  wire wrStop = wrPend & (wrAddr == OFS_STOP);
  wire wrTxWait = wrPend & (wrAddr == OFS_TXWAIT);
  wire wrTimeout = wrPend & (wrAddr == OFS_TIMEOUT);
  wire wrErrLim = wrPend & (wrAddr == OFS_ERRLIM);
  wire wrIrqStat = wrPend & (wrAddr == OFS_IRQ_STAT);
  wire wrIrqMask = wrPend & (wrAddr == OFS_IRQ_MASK);
  wire [31:0] statusWord = (32'(slaveAddr) << ST_ADDR_LSB)
    | (32'(rateCode) << ST_RATE_LSB)
    | (32'(linkEnable) << ST_VALID)
    | (32'(state) << ST_STATE_LSB);
  wire [31:0] regRdata =
    (muxAddr == OFS_PARITY) ? 32'(parityMode) :
    (muxAddr == OFS_STOP) ? 32'(twoStopBits) :
    (muxAddr == OFS_TXWAIT) ? 32'(txWait) :
    (muxAddr == OFS_TIMEOUT) ? 32'(timeoutMs) :
    (muxAddr == OFS_ERRLIM) ? 32'(errLimit) :
    (muxAddr == OFS_STATUS) ? statusWord :
    (muxAddr == OFS_IRQ_STAT) ? 32'(irqStat) :
    (muxAddr == OFS_IRQ_MASK) ? 32'(irqMask) : 32'h0000_0000;

  // Clamped write values
  wire [6:0] wdTxWait = (hwdata[31:7] != 25'h0 || hwdata[6:0] > TXWAIT_MAX)
    ? TXWAIT_MAX : hwdata[6:0];
  wire [13:0] wdTimeout =
    (hwdata[31:14] != 18'h0 || hwdata[13:0] > TIMEOUT_MAX)
    ? TIMEOUT_MAX : hwdata[13:0];
  wire [3:0] wdErrLim = (hwdata[31:4] != 28'h0 || hwdata[3:0] > ERRLIM_MAX)
    ? ERRLIM_MAX : hwdata[3:0];
  // Parity code 3 is meaningless, so such a write is dropped
  wire parityOk = hwdata[1:0] <= PAR_ODD;

  // Switch validity and address
  wire rateOk = rateCode <= RATE_115200;
  wire rotOk = addrExt | (addrRot != ROT_UNUSED);
  wire [4:0] next_slaveAddr = {addrExt, addrRot};

  // Timers
  wire msTick = msCnt == 16'(MS_CYC - 1);
  wire anyFrame = frameRcvd & linkEnable;
  wire forUs = anyFrame & (frameAddr == {3'h0, slaveAddr});
  wire forAll = anyFrame & (frameAddr == BCAST_ADDR);
  // Busy with a reply: a too-close request is not answered
  wire accUni = forUs & (state == ST_IDLE);
  wire accBc = forAll & (state == ST_IDLE);
  wire toFire = toArmed & (timeoutMs != 14'h0) & msTick
    & (toCnt == timeoutMs - 14'h1);
  wire [3:0] errInc = errCnt + 4'h1;
  wire errFire = commErr & (errLimit != 4'h0) & (errInc == errLimit);
  wire gapDone = seqCnt == gapCyc - 20'h1;
  wire msStep = seqCnt == 20'(MS_CYC - 1);
  wire waitDone = (txWait == 7'h0)
    | (msStep & (waitMs == txWait - 7'h1));
  wire [IRQ_W-1:0] events;
  assign events[IRQ_TIMEOUT] = toFire;
  assign events[IRQ_ERRALARM] = errFire;
  assign events[IRQ_UNICAST] = accUni;
  assign events[IRQ_BCAST] = accBc;
  // A new event beats a clear in the same cycle
  wire [IRQ_W-1:0] next_irqStat =
    (irqStat & ~(wrIrqStat ? hwdata[IRQ_W-1:0] : {IRQ_W{1'b0}})) | events;

  // Switch capture while reset is held
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rateCode <= {rateSelBit2, rateSelBit1, rateSelBit0};
      addrExt <= addrExtensionSwitch;
      addrRot <= addrRotarySelector;
    end
  end

  // Derived link settings
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      linkEnable <= 1'b0;
      bitDiv <= 16'h0000;
      slaveAddr <= 5'h00;
      gapCyc <= 20'h00000;
    end else begin
      linkEnable <= rateOk & rotOk;
      bitDiv <= calc_bit_div(rateCode);
      slaveAddr <= next_slaveAddr;
      gapCyc <= calc_gap(rateCode);
    end
  end

  // Settings registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      parityMode <= PARITY_RST;
      twoStopBits <= STOP_RST;
      txWait <= TXWAIT_RST;
      timeoutMs <= TIMEOUT_RST;
      errLimit <= ERRLIM_RST;
      irqMask <= {IRQ_W{1'b0}};
    end else begin
      if (wrParity && parityOk) parityMode <= hwdata[1:0];
      if (wrStop) twoStopBits <= hwdata[0];
      if (wrTxWait) txWait <= wdTxWait;
      if (wrTimeout) timeoutMs <= wdTimeout;
      if (wrErrLim) errLimit <= wdErrLim;
      if (wrIrqMask) irqMask <= hwdata[IRQ_W-1:0];
    end
  end

  // Interrupt status and output
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqStat <= {IRQ_W{1'b0}};
      irq <= 1'b0;
      timeoutAlarm <= 1'b0;
      errorAlarm <= 1'b0;
    end else begin
      irqStat <= next_irqStat;
      irq <= |(next_irqStat & irqMask);
      timeoutAlarm <= next_irqStat[IRQ_TIMEOUT];
      errorAlarm <= next_irqStat[IRQ_ERRALARM];
    end
  end

  // AHB-Lite pipeline; a read right behind a write takes one wait
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
      rdLate <= 1'b0;
      rdAddr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      wrPend <= addrPhase & hwrite;
      if (addrPhase) wrAddr <= haddr[7:0];
      rdLate <= rdStall;
      if (rdStall) rdAddr <= haddr[7:0];
      hreadyout <= ~rdStall;
      if ((rdReq && !wrPend) || rdLate) hrdata <= regRdata;
    end
  end

  // Millisecond enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      msCnt <= 16'h0000;
    end else begin
      msCnt <= msTick ? 16'h0000 : msCnt + 16'h1;
    end
  end

  // Message interval watch, armed by the first message
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      toCnt <= 14'h0000;
      toArmed <= 1'b0;
    end else if (anyFrame) begin
      toCnt <= 14'h0000;
      toArmed <= 1'b1;
    end else if (toFire) begin
      toArmed <= 1'b0;
    end else if (msTick && toArmed) begin
      toCnt <= toCnt + 14'h1;
    end
  end

  // Error counting
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      errCnt <= 4'h0;
    end else if (errFire || forUs) begin
      errCnt <= 4'h0;
    end else if (commErr && errLimit != 4'h0) begin
      errCnt <= errInc;
    end
  end

  // Request acceptance
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      execReq <= 1'b0;
      execBcast <= 1'b0;
    end else begin
      execReq <= accUni | accBc;
      execBcast <= accBc;
    end
  end

  // Reply sequencing; only an accepted unicast request starts it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      seqCnt <= 20'h00000;
      waitMs <= 7'h00;
      procSeen <= 1'b0;
      respGo <= 1'b0;
    end else begin
      respGo <= 1'b0;
      if (state != ST_IDLE && procDone) procSeen <= 1'b1;
      case (state)
        ST_IDLE: begin
          seqCnt <= 20'h00000;
          procSeen <= 1'b0;
          if (accUni) state <= ST_GAP;
        end
        ST_GAP: begin
          seqCnt <= seqCnt + 20'h1;
          if (gapDone) state <= ST_PROC;
        end
        ST_PROC: begin
          seqCnt <= 20'h00000;
          waitMs <= 7'h00;
          if (procSeen || procDone) state <= ST_WAIT;
        end
        ST_WAIT: begin
          seqCnt <= msStep ? 20'h00000 : seqCnt + 20'h1;
          if (msStep) waitMs <= waitMs + 7'h1;
          if (waitDone) begin
            respGo <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // mbs_link_setup

//--- hdl/mbs_pkg.sv
// Constants and types for the Modbus slave link setup block
package mbs_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_PER_S = 1000;
  localparam int US_PER_S = 1_000_000;
  localparam int BAUD_9600 = 9600;
  localparam int BAUD_19200 = 19200;
  localparam int BAUD_38400 = 38400;
  localparam int BAUD_57600 = 57600;
  localparam int BAUD_115200 = 115200;
  localparam logic [2:0] RATE_9600 = 3'h0;
  localparam logic [2:0] RATE_19200 = 3'h1;
  localparam logic [2:0] RATE_38400 = 3'h2;
  localparam logic [2:0] RATE_57600 = 3'h3;
  localparam logic [2:0] RATE_115200 = 3'h4;
  // Silent gap times in microseconds
  localparam int GAP_SLOW_US = 4000;
  localparam int GAP_MID_US = 2000;
  localparam int GAP_FAST_US = 1750;
  // Register byte offsets
  localparam logic [7:0] OFS_PARITY = 8'h00;
  localparam logic [7:0] OFS_STOP = 8'h04;
  localparam logic [7:0] OFS_TXWAIT = 8'h08;
  localparam logic [7:0] OFS_TIMEOUT = 8'h0c;
  localparam logic [7:0] OFS_ERRLIM = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
  // Reset values and limits
  localparam logic [1:0] PARITY_RST = 2'h1;
  localparam logic STOP_RST = 1'h0;
  localparam logic [6:0] TXWAIT_RST = 7'h0a;
  localparam logic [6:0] TXWAIT_MAX = 7'h64;
  localparam logic [13:0] TIMEOUT_RST = 14'h0000;
  localparam logic [13:0] TIMEOUT_MAX = 14'h2710;
  localparam logic [3:0] ERRLIM_RST = 4'h3;
  localparam logic [3:0] ERRLIM_MAX = 4'ha;
  localparam logic [1:0] PAR_ODD = 2'h2;
  // Interrupt bits
  localparam int IRQ_W = 4;
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_ERRALARM = 1;
  localparam int IRQ_UNICAST = 2;
  localparam int IRQ_BCAST = 3;
  // Addressing
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [3:0] ROT_UNUSED = 4'h0;
  // Status register field positions
  localparam int ST_ADDR_LSB = 0;
  localparam int ST_RATE_LSB = 8;
  localparam int ST_VALID = 12;
  localparam int ST_STATE_LSB = 16;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_GAP = 4'b0010,
    ST_PROC = 4'b0100,
    ST_WAIT = 4'b1000
  } mbs_resp_state_t;
endpackage

//--- test/mbs_link_setup_checker.sv
// Port assertions for the Modbus slave link setup block
`timescale 1ns/100ps
module mbs_link_setup_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic hresp,
  input wire logic frameRcvd,
  input wire logic [7:0] frameAddr,
  input wire logic linkEnable,
  input wire logic [15:0] bitDiv,
  input wire logic [1:0] parityMode,
  input wire logic [4:0] slaveAddr,
  input wire logic execReq,
  input wire logic execBcast,
  input wire logic respGo
);
  logic pend;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence uni_s; execReq && !execBcast; endsequence
  sequence quiet_s; !respGo [*8]; endsequence
  // Reply owed only after a unicast acceptance
  always_ff @(posedge clk) begin
    if (!rst_n) pend <= 1'b0;
    else if (execReq && !execBcast) pend <= 1'b1;
    else if (respGo) pend <= 1'b0;
  end
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  accept_src_a: assert property (execReq |-> $past(frameRcvd) &&
    ($past(frameAddr) == {3'h0, $past(slaveAddr)} ||
    $past(frameAddr) == 8'h00)) else $error("request without frame");
  bcast_addr_a: assert property (execBcast |-> execReq &&
    $past(frameAddr) == 8'h00) else $error("broadcast flag wrong");
  bcast_quiet_a: assert property (execBcast |=> quiet_s)
    else $error("response after broadcast");
  gap_quiet_a: assert property (uni_s |=> quiet_s)
    else $error("response before silent gap");
  reply_only_a: assert property (respGo |-> pend)
    else $error("response without request");
  drop_busy_a: assert property (pend && !respGo && frameRcvd
    |=> !execReq) else $error("frame taken while busy");
  link_valid_a: assert property (linkEnable |-> slaveAddr != 5'h00 &&
    bitDiv inside {16'h1458, 16'h0a2c, 16'h0516, 16'h0364, 16'h01b2})
    else $error("link enabled with bad setting");
  parity_legal_a: assert property (parityMode != 2'h3)
    else $error("parity mode out of range");
endmodule // mbs_link_setup_checker
bind mbs_link_setup mbs_link_setup_checker chk (.clk(clk), .rst_n(rst_n),
  .hresp(hresp), .frameRcvd(frameRcvd), .frameAddr(frameAddr),
  .linkEnable(linkEnable), .bitDiv(bitDiv), .parityMode(parityMode),
  .slaveAddr(slaveAddr), .execReq(execReq), .execBcast(execBcast),
  .respGo(respGo));

//--- test/mbs_link_setup_tb.sv
// Self-checking bench for the Modbus slave link setup block
`timescale 1ns/100ps
module mbs_link_setup_tb;
  import mbs_pkg::*;
  typedef struct packed {
    logic [7:0] o;
    logic w;
    logic [31:0] d;
    logic [31:0] e;
  } mbs_row_t;
  mbs_row_t rows [16] = '{
    '{OFS_PARITY, 1'b0, 32'h0, 32'h1},
    '{OFS_STOP, 1'b0, 32'h0, 32'h0},
    '{OFS_TXWAIT, 1'b0, 32'h0, 32'ha},
    '{OFS_TIMEOUT, 1'b0, 32'h0, 32'h0},
    '{OFS_ERRLIM, 1'b0, 32'h0, 32'h3},
    '{OFS_STATUS, 1'b1, 32'h0, 32'h11401},
    '{OFS_PARITY, 1'b1, 32'h2, 32'h2},
    '{OFS_PARITY, 1'b1, 32'h3, 32'h2},
    '{OFS_STOP, 1'b1, 32'h1, 32'h1},
    '{OFS_TXWAIT, 1'b1, 32'hc8, 32'h64},
    '{OFS_TXWAIT, 1'b1, 32'h1, 32'h1},
    '{OFS_TIMEOUT, 1'b1, 32'h3000, 32'h2710},
    '{OFS_TIMEOUT, 1'b1, 32'h2, 32'h2},
    '{OFS_ERRLIM, 1'b1, 32'hf, 32'ha},
    '{OFS_ERRLIM, 1'b1, 32'h2, 32'h2},
    '{8'h20, 1'b1, 32'h5, 32'h0}
  };
  int divs [5] = '{CLK_HZ / BAUD_9600, CLK_HZ / BAUD_19200,
    CLK_HZ / BAUD_38400, CLK_HZ / BAUD_57600, CLK_HZ / BAUD_115200};
  int failures = 0, checkCount = 0, reqN = 0, bcN = 0, rspN = 0;
  int cyc = 0, reqAt = 0, rspAt = 0;
  // Gap cycles per rate code, as overridden on the instance
  int gaps [5] = '{40, 30, 25, 25, 25};
  logic clk, rst_n, hsel, hwrite, ext;
  logic [1:0] htrans, parityMode;
  logic [31:0] haddr, hwdata, rd, hrdata;
  logic [2:0] rate;
  logic [3:0] rot;
  logic hreadyout, hresp, frameRcvd, commErr, procDone, linkEnable, irq;
  logic twoStopBits, execReq, execBcast, respGo, timeoutAlarm, errorAlarm;
  logic [7:0] frameAddr;
  logic [15:0] bitDiv;
  logic [4:0] slaveAddr;
  // Short ms and gap counts keep the run small
  mbs_link_setup #(.MS_CYC(20), .GAP_SLOW_CYC(40), .GAP_MID_CYC(30),
    .GAP_FAST_CYC(25)) dut (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rateSelBit0(rate[0]),
    .rateSelBit1(rate[1]), .rateSelBit2(rate[2]),
    .addrExtensionSwitch(ext), .addrRotarySelector(rot),
    .frameRcvd(frameRcvd), .frameAddr(frameAddr), .commErr(commErr),
    .procDone(procDone), .linkEnable(linkEnable), .bitDiv(bitDiv),
    .parityMode(parityMode), .twoStopBits(twoStopBits),
    .slaveAddr(slaveAddr), .execReq(execReq), .execBcast(execBcast),
    .respGo(respGo), .timeoutAlarm(timeoutAlarm),
    .errorAlarm(errorAlarm), .irq(irq));
  mbs_master_model mdl (.clk(clk), .execReq(execReq),
    .frameRcvd(frameRcvd), .frameAddr(frameAddr), .commErr(commErr),
    .procDone(procDone));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (execReq) reqN++;
    if (execReq) reqAt = cyc;
    if (execBcast) bcN++;
    if (respGo) rspN++;
    if (respGo) rspAt = cyc;
  end
  task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    checkCount++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic boot(input logic [2:0] r, input logic x,
      input logic [3:0] v);
    rst_n <= 1'b0;
    rate <= r;
    ext <= x;
    rot <= v;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    haddr <= 32'h0;
    hwdata <= 32'h0;
    boot(3'h4, 1'b0, 4'h1);
    chk("bitDiv", 32'(divs[4]), 32'(bitDiv));
    chk("slaveAddr", 32'h1, 32'(slaveAddr));
    foreach (rows[i]) begin
      if (rows[i].w) ahb(1'b1, rows[i].o, rows[i].d);
      ahb(1'b0, rows[i].o, 32'h0);
      chk("register", rows[i].e, rd);
    end
    chk("stop bits", 32'h1, 32'(twoStopBits));
    chk("parity", 32'h2, 32'(parityMode));
    ahb(1'b1, OFS_IRQ_MASK, 32'hf);
    mdl.query(8'h01);
    mdl.query(8'h01);
    repeat (60) @(posedge clk);
    chk("requests", 32'h1, 32'(reqN));
    chk("responses", 32'h1, 32'(rspN));
    chk("delay", 32'h1, 32'((rspAt - reqAt) inside {[45:49]}));
    chk("irq", 32'h1, 32'(irq));
    mdl.query(8'h00);
    mdl.query(8'h05);
    repeat (60) @(posedge clk);
    chk("broadcasts", 32'h1, 32'(bcN));
    chk("responses", 32'h1, 32'(rspN));
    chk("requests", 32'h2, 32'(reqN));
    ahb(1'b1, OFS_IRQ_STAT, 32'hf);
    mdl.query(8'h00);
    repeat (20) @(posedge clk);
    chk("timeout alarm", 32'h1, 32'(timeoutAlarm));
    mdl.fault;
    chk("error alarm", 32'h0, 32'(errorAlarm));
    mdl.fault;
    chk("error alarm", 32'h1, 32'(errorAlarm));
    ahb(1'b1, OFS_IRQ_MASK, 32'h0);
    ahb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("irq status", 32'hb, rd);
    chk("masked irq", 32'h0, 32'(irq));
    ahb(1'b1, OFS_IRQ_STAT, 32'hf);
    ahb(1'b1, OFS_IRQ_MASK, 32'hf);
    ahb(1'b1, OFS_TIMEOUT, 32'h0);
    chk("cleared irq", 32'h0, 32'(irq));
    mdl.query(8'h00);
    repeat (60) @(posedge clk);
    chk("timeout off", 32'h0, 32'(timeoutAlarm));
    chk("irq", 32'h1, 32'(irq));
    for (int c = 0; c < 8; c++) begin
      boot(3'(c), 1'b0, 4'h1);
      chk("bitDiv", c < 5 ? 32'(divs[c]) : 32'h0, 32'(bitDiv));
      chk("link", 32'(c < 5), 32'(linkEnable));
      mdl.query(8'h01);
      // Default wait of 10 ms is 200 cycles at the short ms count
      if (c < 5) begin
        repeat (250) @(posedge clk);
        chk("rate delay", 32'h1, 32'((rspAt - reqAt) inside
          {[gaps[c] + 200:gaps[c] + 204]}));
      end
    end
    chk("requests", 32'h9, 32'(reqN));
    boot(3'h0, 1'b1, 4'h3);
    chk("slaveAddr", 32'h13, 32'(slaveAddr));
    boot(3'h4, 1'b0, 4'h0);
    chk("link", 32'h0, 32'(linkEnable));
    end_sim;
  end
  // Whole run is a few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_sim;
  end
endmodule // mbs_link_setup_tb

//--- test/mbs_master_model.sv
// Modbus master stand-in: frame and error events toward the slave
`timescale 1ns/100ps
module mbs_master_model (
  // Clock and device side
  input wire logic clk,
  input wire logic execReq,
  // Frame events
  output logic frameRcvd,
  output logic [7:0] frameAddr,
  output logic commErr,
  output logic procDone
);
  logic [2:0] busy = 3'h0;
  initial begin
    frameRcvd = 1'b0;
    frameAddr = 8'h5a;
    commErr = 1'b0;
    procDone = 1'b0;
  end
  // Processing ends well inside the gap, so latency is fixed
  always @(posedge clk) begin
    busy <= {busy[1:0], execReq};
    procDone <= busy[2];
  end
  // Address line scrambled once the frame is gone
  task automatic query(input logic [7:0] a);
    frameRcvd <= 1'b1;
    frameAddr <= a;
    @(posedge clk);
    frameRcvd <= 1'b0;
    frameAddr <= ~a;
    repeat (30) @(posedge clk);
  endtask
  task automatic fault;
    commErr <= 1'b1;
    @(posedge clk);
    commErr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
endmodule // mbs_master_model
